// *** core/lsmnc_pkg.sv ***
// Package: constants and types for the lane sample mapper and sync timing
package lsmnc_pkg;
    localparam int NUM_LANES = 16;
    localparam int OCTET_W = 8;
    localparam int LANE_W = 64;
    localparam int S12_W = 12;
    localparam int S8_W = 8;
    localparam int NUM_SLOTS = 20;
    localparam int S12_PER_LANE = 5;
    localparam int TAIL_LSB = 0;
    localparam int LANES_4 = 4;
    localparam int LANES_6 = 6;
    localparam int LANES_8 = 8;
    // SYSREF latency in half cycles: 477.5 cycles
    localparam int SYSREF_HALF_CYCLES = 955;
    localparam int SYSREF_LAT_CYC = (SYSREF_HALF_CYCLES + 1) / 2;
    localparam int LAT_W = 16;
    localparam int MF_PHASE_W = 4;
    typedef enum logic [2:0] {
        LSMNC_M12_L6,
        LSMNC_M12_L4,
        LSMNC_M12_L3,
        LSMNC_M8_L16,
        LSMNC_M8_L8,
        LSMNC_M8_L4
    } lsmnc_mode_e;
    typedef logic [S12_W-1:0] lsmnc_s12_t;
    typedef logic [LANE_W-1:0] lsmnc_lane_t;
endpackage

// *** core/lsmnc_lat_if.sv ***
// Interface: latency table lookup between top and lookup module
`timescale 1ns/1ns
`default_nettype none
interface lsmnc_lat_if;
    logic [7:0] interp_factor;
    logic [lsmnc_pkg::MF_PHASE_W-1:0] mf_phase;
    logic signed [lsmnc_pkg::LAT_W-1:0] latency;
    modport req (output interp_factor, output mf_phase, input latency);
    modport rsp (input interp_factor, input mf_phase, output latency);
endinterface
`default_nettype wire

// *** core/lsmnc_lat_lut.sv ***
// Module: data sync latency table by interpolation factor and multiframe phase
`timescale 1ns/1ns
`default_nettype none
module lsmnc_lat_lut (
    lsmnc_lat_if.rsp lat
);
    import lsmnc_pkg::*;
    logic [2:0] p8;
    logic [1:0] p4;
    logic p2;
    logic signed [LAT_W-1:0] v;
    assign p8 = lat.mf_phase[2:0];
    assign p4 = lat.mf_phase[1:0];
    assign p2 = lat.mf_phase[0];
    // Filter path minus marker path, by multiframe phase for factors 2 to 12 and 24; one value for 16 and for 32 up
    always_comb begin
        v = 16'sh0000;
        case (lat.interp_factor)
            8'h02: v = 16'sh0000 - 16'sd144 + $signed({12'h000, p8, 1'b0});
            8'h03: begin
                case (lat.mf_phase)
                    4'h0: v = -16'sd89;
                    4'h1: v = -16'sd86;
                    4'h2: v = -16'sd83;
                    4'h3: v = -16'sd81;
                    4'h4: v = -16'sd80;
                    4'h5: v = -16'sd78;
                    4'h6: v = -16'sd77;
                    4'h7: v = -16'sd75;
                    4'h8: v = -16'sd74;
                    4'h9: v = -16'sd72;
                    4'ha: v = -16'sd71;
                    4'hb: v = -16'sd69;
                    4'hc: v = -16'sd68;
                    4'hd: v = -16'sd66;
                    4'he: v = -16'sd63;
                    default: v = -16'sd60;
                endcase
            end
            8'h04: v = 16'sh0000 - 16'sd36 + $signed({12'h000, p4, 2'h0});
            8'h06: begin
                case (p8)
                    3'h0: v = 16'sd34;
                    3'h1: v = 16'sd40;
                    3'h2: v = 16'sd42;
                    3'h3: v = 16'sd46;
                    3'h4: v = 16'sd48;
                    3'h5: v = 16'sd52;
                    3'h6: v = 16'sd54;
                    default: v = 16'sd60;
                endcase
            end
            8'h08: v = p2 ? 16'sd94 : 16'sd86;
            8'h0c: begin
                case (p4)
                    2'h0: v = 16'sd186;
                    2'h1: v = 16'sd194;
                    2'h2: v = 16'sd198;
                    default: v = 16'sd206;
                endcase
            end
            8'h10: v = 16'sd290;
            8'h18: v = p2 ? 16'sd466 : 16'sd458;
            8'h20: v = 16'sd648;
            8'h30: v = 16'sd968;
            8'h40: v = 16'sd1396;
            8'h60: v = 16'sd2036;
            8'h80: v = 16'sd2932;
            8'hc0: v = 16'sd4212;
            8'h00: v = 16'sd6004;
            default: v = 16'sh0000;
        endcase
    end
    assign lat.latency = v;
endmodule // lsmnc_lat_lut
`default_nettype wire

// *** core/lsmnc_top.sv ***
// Module: lane unpacker and oscillator sync event timing
`timescale 1ns/1ns
`default_nettype none
module lsmnc_top (
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire lsmnc_pkg::lsmnc_mode_e lane_format_mode_i,
    input wire logic [lsmnc_pkg::NUM_LANES*lsmnc_pkg::LANE_W-1:0] lanes_i,
    input wire logic lanes_valid_i,
    input wire logic sysref_i,
    input wire logic marker_i,
    input wire logic [7:0] interpolation_factor_i,
    input wire logic [lsmnc_pkg::MF_PHASE_W-1:0] mf_phase_i,
    output logic [lsmnc_pkg::NUM_SLOTS*lsmnc_pkg::S12_W-1:0] channel_inphase_samples_o,
    output logic [lsmnc_pkg::NUM_SLOTS*lsmnc_pkg::S12_W-1:0] channel_quadrature_samples_o,
    output logic samples_valid_o,
    output logic sysref_sync_o,
    output logic signed [lsmnc_pkg::LAT_W-1:0] data_sync_latency_o,
    output logic marker_sync_o
);
    import lsmnc_pkg::*;

    // ************************************************
    // Lane unpacking
    // ************************************************
    logic [NUM_SLOTS*S12_W-1:0] i_next;
    logic [NUM_SLOTS*S12_W-1:0] q_next;
    logic [NUM_SLOTS*S12_W-1:0] i_reg;
    logic [NUM_SLOTS*S12_W-1:0] q_reg;
    logic valid_reg;

    // ************************************************
    // Lane views
    // ************************************************
    // Leading octet pair of each lane, nibble 0 on top
    wire [2*OCTET_W-1:0] lane_lead [NUM_LANES];
    // Five 12-bit slots of the first eight lanes; nibble 15 is tail
    wire [S12_W-1:0] lane_slot [LANES_8][S12_PER_LANE];
    // Three-lane groups as 48-bit words, first lane in the top bits
    wire [6*OCTET_W-1:0] grp_word [4];
    // Slot vectors per lane format; the two packed formats share p12, w16 has no quadrature vector
    wire [NUM_SLOTS*S12_W-1:0] p12_i;
    wire [NUM_SLOTS*S12_W-1:0] p12_q;
    wire [NUM_SLOTS*S12_W-1:0] t12_i;
    wire [NUM_SLOTS*S12_W-1:0] t12_q;
    wire [NUM_SLOTS*S12_W-1:0] w16_i;
    wire [NUM_SLOTS*S12_W-1:0] w8_i;
    wire [NUM_SLOTS*S12_W-1:0] w8_q;
    wire [NUM_SLOTS*S12_W-1:0] w4_i;
    wire [NUM_SLOTS*S12_W-1:0] w4_q;

    for (genvar k = 0; k < NUM_LANES; k++) begin : g_lane
        assign lane_lead[k] = lanes_i[k*LANE_W+LANE_W-1 -: 2*OCTET_W];
    end

    for (genvar k = 0; k < LANES_8; k++) begin : g_four
        for (genvar m = 0; m < S12_PER_LANE; m++) begin : g_slot
            assign lane_slot[k][m] = lanes_i[k*LANE_W+LANE_W-1-S12_W*m -: S12_W];
        end
    end

    for (genvar g = 0; g < 4; g++) begin : g_group
        assign grp_word[g] = {lane_lead[3*g], lane_lead[3*g+1], lane_lead[3*g+2]};
    end

    for (genvar j = 0; j < NUM_SLOTS; j++) begin : g_map
        // Four-lane 12-bit: lane j mod 4, sample slot j div 4
        assign t12_i[j*S12_W +: S12_W] = lane_slot[j%LANES_4][j/LANES_4];
        assign t12_q[j*S12_W +: S12_W] = lane_slot[LANES_4+j%LANES_4][j/LANES_4];
        // Packed 12-bit: sample j mod 4 of group j div 4
        if (j < LANES_8) begin : g_packed
            assign p12_i[j*S12_W +: S12_W] = grp_word[j/4][6*OCTET_W-1-S12_W*(j%4) -: S12_W];
            assign p12_q[j*S12_W +: S12_W] = grp_word[2+j/4][6*OCTET_W-1-S12_W*(j%4) -: S12_W];
        end else begin : g_packed_idle
            assign p12_i[j*S12_W +: S12_W] = '0;
            assign p12_q[j*S12_W +: S12_W] = '0;
        end
        // 8-bit formats: octet 0 left-justified, low nibble zero
        if (j < NUM_LANES) begin : g_w16
            assign w16_i[j*S12_W +: S12_W] = {lane_lead[j][2*OCTET_W-1 -: S8_W], 4'h0};
        end else begin : g_w16_idle
            assign w16_i[j*S12_W +: S12_W] = '0;
        end
        if (j < LANES_8) begin : g_w8
            assign w8_i[j*S12_W +: S12_W] = {lane_lead[j][2*OCTET_W-1 -: S8_W], 4'h0};
            assign w8_q[j*S12_W +: S12_W] = {lane_lead[LANES_8+j][2*OCTET_W-1 -: S8_W], 4'h0};
        end else begin : g_w8_idle
            assign w8_i[j*S12_W +: S12_W] = '0;
            assign w8_q[j*S12_W +: S12_W] = '0;
        end
        if (j < LANES_4) begin : g_w4
            assign w4_i[j*S12_W +: S12_W] = {lane_lead[j][2*OCTET_W-1 -: S8_W], 4'h0};
            assign w4_q[j*S12_W +: S12_W] = {lane_lead[LANES_4+j][2*OCTET_W-1 -: S8_W], 4'h0};
        end else begin : g_w4_idle
            assign w4_i[j*S12_W +: S12_W] = '0;
            assign w4_q[j*S12_W +: S12_W] = '0;
        end
    end

    // ************************************************
    // Format select
    // ************************************************
    // The three-lane format carries one stream only
    always_comb begin
        i_next = '0;
        q_next = '0;
        case (lane_format_mode_i)
            LSMNC_M12_L6: begin
                i_next = p12_i;
                q_next = p12_q;
            end
            LSMNC_M12_L3: begin
                i_next = p12_i;
                q_next = '0;
            end
            LSMNC_M12_L4: begin
                i_next = t12_i;
                q_next = t12_q;
            end
            LSMNC_M8_L16: begin
                i_next = w16_i;
                q_next = '0;
            end
            LSMNC_M8_L8: begin
                i_next = w8_i;
                q_next = w8_q;
            end
            LSMNC_M8_L4: begin
                i_next = w4_i;
                q_next = w4_q;
            end
            default: begin
                i_next = '0;
                q_next = '0;
            end
        endcase
    end

    // ************************************************
    // Sample registers
    // ************************************************
    // Data hold until the next valid transfer
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            i_reg <= '0;
            q_reg <= '0;
        end else if (lanes_valid_i) begin
            i_reg <= i_next;
            q_reg <= q_next;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            valid_reg <= 1'b0;
        end else begin
            valid_reg <= lanes_valid_i;
        end
    end
    assign channel_inphase_samples_o = i_reg;
    assign channel_quadrature_samples_o = q_reg;
    assign samples_valid_o = valid_reg;

    // ************************************************
    // SYSREF triggered sync
    // ************************************************
    logic sysref_d_reg;
    logic [LAT_W-1:0] sr_cnt_reg;
    logic [LAT_W-1:0] sr_cnt_next;
    logic sr_busy_reg;
    logic sr_fire_reg;
    wire sr_rise = sysref_i & ~sysref_d_reg;
    wire sr_done = sr_busy_reg && (sr_cnt_reg == 16'h0001);
    // A new rise reloads the count, so the latest request sets the time
    wire sr_step = sr_busy_reg & ~sr_done;
    assign sr_cnt_next = sr_rise ? LAT_W'(SYSREF_LAT_CYC) : (sr_step ? sr_cnt_reg - 16'h0001 : 16'h0000);

    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            sysref_d_reg <= 1'b0;
            sr_cnt_reg <= '0;
            sr_busy_reg <= 1'b0;
            sr_fire_reg <= 1'b0;
        end else begin
            sysref_d_reg <= sysref_i;
            sr_cnt_reg <= sr_cnt_next;
            sr_busy_reg <= sr_rise | sr_step;
            // A rise in the done cycle cancels the old pulse
            sr_fire_reg <= sr_done & ~sr_rise;
        end
    end
    assign sysref_sync_o = sr_fire_reg;

    // ************************************************
    // Marker triggered sync
    // ************************************************
    lsmnc_lat_if lat_bus ();
    assign lat_bus.interp_factor = interpolation_factor_i;
    assign lat_bus.mf_phase = mf_phase_i;
    lsmnc_lat_lut u_lut (
        .lat(lat_bus)
    );

    logic marker_d_reg;
    logic signed [LAT_W-1:0] lat_reg;
    logic mk_fire_reg;
    // A marker held high syncs once; only its rising edge counts
    wire mk_rise = marker_i & ~marker_d_reg;

    // Latency latched at the marker edge, by its multiframe phase
    always_ff @(posedge clk_sys_i) begin
        if (srst_i) begin
            marker_d_reg <= 1'b0;
            lat_reg <= '0;
            mk_fire_reg <= 1'b0;
        end else begin
            marker_d_reg <= marker_i;
            mk_fire_reg <= mk_rise;
            if (mk_rise) lat_reg <= lat_bus.latency;
        end
    end
    assign data_sync_latency_o = lat_reg;
    assign marker_sync_o = mk_fire_reg;
endmodule // lsmnc_top
`default_nettype wire

// *** bench/lsmnc_checker_assertions.sv ***
// Checker: port-level assertions for the lane mapper and sync timing
`timescale 1ns/1ns
`default_nettype none
module lsmnc_checker
    import lsmnc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic srst_i,
    input wire lsmnc_mode_e lane_format_mode_i,
    input wire logic [NUM_LANES*LANE_W-1:0] lanes_i,
    input wire logic lanes_valid_i,
    input wire logic sysref_i,
    input wire logic marker_i,
    input wire logic [7:0] interpolation_factor_i,
    input wire logic [NUM_SLOTS*S12_W-1:0] channel_inphase_samples_o,
    input wire logic [NUM_SLOTS*S12_W-1:0] channel_quadrature_samples_o,
    input wire logic samples_valid_o,
    input wire logic sysref_sync_o,
    input wire logic signed [LAT_W-1:0] data_sync_latency_o,
    input wire logic marker_sync_o
);
    logic sr_q, mk_q;
    logic [9:0] cnt;
    wire sr_rise = sysref_i && !sr_q;
    wire mk_rise = marker_i && !mk_q;
    // Edge history and cycles since the last sync request
    always_ff @(posedge clk_sys_i) begin
        sr_q <= srst_i ? 1'b0 : sysref_i;
        mk_q <= srst_i ? 1'b0 : marker_i;
        cnt <= srst_i ? 10'h000 : sr_rise ? 10'h001 : (cnt != 10'h000 && cnt != 10'h3ff) ? cnt + 10'h001 : cnt;
    end
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (srst_i);
    a_valid_delay: assert property (1'b1 |=> samples_valid_o == $past(lanes_valid_i))
        else $error("valid not delayed by one");
    a_data_hold: assert property (!lanes_valid_i |=> $stable(channel_inphase_samples_o)
        && $stable(channel_quadrature_samples_o)) else $error("samples moved without valid");
    a_m12_first: assert property (lanes_valid_i && lane_format_mode_i == LSMNC_M12_L6
        |=> channel_quadrature_samples_o[11:0] == $past(lanes_i[447:436])) else $error("q0 wrong");
    a_m8_first: assert property (lanes_valid_i && lane_format_mode_i == LSMNC_M8_L16
        |=> channel_inphase_samples_o[11:0] == {$past(lanes_i[63:56]), 4'h0}) else $error("i0 wrong");
    a_sysref_time: assert property (sysref_sync_o == (cnt == 10'h1df))
        else $error("sysref sync pulse mistimed");
    a_marker_pulse: assert property (1'b1 |=> marker_sync_o == $past(mk_rise))
        else $error("marker sync pulse mistimed");
    a_lat_hold: assert property (!mk_rise |=> $stable(data_sync_latency_o))
        else $error("latency changed without marker");
    a_lat_f16: assert property (mk_rise && interpolation_factor_i == 8'h10
        |=> data_sync_latency_o == 16'sh0122) else $error("latency at 16 wrong");
    a_lat_f32: assert property (mk_rise && interpolation_factor_i == 8'h20
        |=> data_sync_latency_o == 16'sh0288) else $error("latency at 32 wrong");
endmodule // lsmnc_checker
bind lsmnc_top lsmnc_checker u_checker (.clk_sys_i(clk_sys_i), .srst_i(srst_i),
    .lane_format_mode_i(lane_format_mode_i), .lanes_i(lanes_i), .lanes_valid_i(lanes_valid_i),
    .sysref_i(sysref_i), .marker_i(marker_i), .interpolation_factor_i(interpolation_factor_i),
    .channel_inphase_samples_o(channel_inphase_samples_o), .samples_valid_o(samples_valid_o),
    .channel_quadrature_samples_o(channel_quadrature_samples_o), .sysref_sync_o(sysref_sync_o),
    .data_sync_latency_o(data_sync_latency_o), .marker_sync_o(marker_sync_o));
`default_nettype wire

// *** bench/lsmnc_tx_model.sv ***
// Partner model: transmitter filling lanes with a counting nibble pattern
`timescale 1ns/1ns
`default_nettype none
module lsmnc_tx_model
    import lsmnc_pkg::*;
(
    input wire logic clk_sys_i,
    input wire logic send_i,
    input wire logic mark_i,
    input wire logic [3:0] seed_i,
    output logic [NUM_LANES*LANE_W-1:0] lanes_o,
    output logic lanes_valid_o,
    output logic marker_o
);
    initial begin
        lanes_o = '0;
        lanes_valid_o = 1'b0;
        marker_o = 1'b0;
    end
    // Nibble n of lane k is seed+3k+n, MSB first; cycles without send_i carry the inverse on every lane
    always @(posedge clk_sys_i) begin
        for (int k = 0; k < NUM_LANES; k++) begin
            for (int n = 0; n < 16; n++) begin
                lanes_o[k*LANE_W+LANE_W-1-4*n -: 4] <= 4'(seed_i + 3 * k + n) ^ {4{~send_i}};
            end
        end
        lanes_valid_o <= send_i;
        marker_o <= mark_i;
    end
endmodule // lsmnc_tx_model
`default_nettype wire

// *** bench/lane_sample_mapper_nco_sync_bench.sv ***
// Testbench: lane unpacking and sync timing scenarios
`timescale 1ns/1ns
`default_nettype none
module lane_sample_mapper_nco_sync_bench;
    import lsmnc_pkg::*;
    logic clk_sys_i, srst_i, sysref_i, send, mark, lvalid, marker, svalid, srsync, mksync;
    lsmnc_mode_e mode;
    logic [3:0] seed, phase;
    logic [7:0] factor;
    logic [NUM_LANES*LANE_W-1:0] lanes;
    logic [NUM_SLOTS*S12_W-1:0] i_o, q_o;
    logic signed [LAT_W-1:0] lat;
    int n_errors = 0;
    int total_checks = 0;
    lsmnc_tx_model u_tx (.clk_sys_i(clk_sys_i), .send_i(send), .mark_i(mark), .seed_i(seed),
        .lanes_o(lanes), .lanes_valid_o(lvalid), .marker_o(marker));
    lsmnc_top DUT (.clk_sys_i(clk_sys_i), .srst_i(srst_i), .lane_format_mode_i(mode), .lanes_i(lanes),
        .lanes_valid_i(lvalid), .sysref_i(sysref_i), .marker_i(marker), .interpolation_factor_i(factor),
        .mf_phase_i(phase), .channel_inphase_samples_o(i_o), .channel_quadrature_samples_o(q_o),
        .samples_valid_o(svalid), .sysref_sync_o(srsync), .data_sync_latency_o(lat), .marker_sync_o(mksync));
    task automatic summarize();
        $display("errors=%0d checks=%0d", n_errors, total_checks);
        if (n_errors == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic chk(input logic ok, input string msg);
        total_checks++;
        if (ok !== 1'b1) begin
            n_errors++;
            $display("CHECK FAILED t=%0t %s", $time, msg);
        end
    endtask
    task automatic wait_hi(ref logic sig, input int lim);
        for (int c = 0; sig !== 1'b1; c++) begin
            if (c == lim) begin
                n_errors++;
                summarize();
            end
            @(negedge clk_sys_i);
        end
    endtask
    function automatic logic [3:0] nb(int k, int n);
        return 4'(seed + 3 * k + n);
    endfunction
    function automatic logic [11:0] pk(int g, int j);
        logic [11:0] r;
        for (int b = 0; b < 3; b++) r = {r[7:0], nb(3 * g + (3 * j + b) / 4, (3 * j + b) % 4)};
        return r;
    endfunction
    function automatic logic [11:0] e8(int k);
        return {nb(k, 0), nb(k, 1), 4'h0};
    endfunction
    // One transfer in mode m, then a held idle cycle
    task automatic t_map(input lsmnc_mode_e m, input logic [3:0] s);
        logic [NUM_SLOTS*S12_W-1:0] ei, eq;
        @(negedge clk_sys_i);
        mode = m;
        seed = s;
        send = 1'b1;
        ei = '0;
        eq = '0;
        for (int j = 0; j < NUM_SLOTS; j++) begin
            case (m)
                LSMNC_M12_L6: begin
                    ei[j*12+:12] = (j < 8) ? pk(j / 4, j % 4) : 12'h000;
                    eq[j*12+:12] = (j < 8) ? pk(2 + j / 4, j % 4) : 12'h000;
                end
                LSMNC_M12_L3: ei[j*12+:12] = (j < 8) ? pk(j / 4, j % 4) : 12'h000;
                LSMNC_M12_L4: begin
                    ei[j*12+:12] = {nb(j % 4, 3 * (j / 4)), nb(j % 4, 3 * (j / 4) + 1), nb(j % 4, 3 * (j / 4) + 2)};
                    eq[j*12+:12] = {nb(4 + j % 4, 3 * (j / 4)), nb(4 + j % 4, 3 * (j / 4) + 1), nb(4 + j % 4, 3 * (j / 4) + 2)};
                end
                LSMNC_M8_L16: ei[j*12+:12] = (j < 16) ? e8(j) : 12'h000;
                LSMNC_M8_L8: begin
                    ei[j*12+:12] = (j < 8) ? e8(j) : 12'h000;
                    eq[j*12+:12] = (j < 8) ? e8(8 + j) : 12'h000;
                end
                default: begin
                    ei[j*12+:12] = (j < 4) ? e8(j) : 12'h000;
                    eq[j*12+:12] = (j < 4) ? e8(4 + j) : 12'h000;
                end
            endcase
        end
        @(negedge clk_sys_i);
        send = 1'b0;
        wait_hi(svalid, 5);
        chk(i_o === ei && q_o === eq, "samples");
        @(negedge clk_sys_i);
        chk(i_o === ei && svalid === 1'b0, "hold");
    endtask
    task automatic t_mark(input logic [7:0] f, input logic [3:0] p, input int e);
        @(negedge clk_sys_i);
        factor = f;
        phase = p;
        mark = 1'b1;
        wait_hi(mksync, 5);
        chk(lat === 16'(e), "latency");
        @(negedge clk_sys_i);
        mark = 1'b0;
        chk(mksync === 1'b0, "pulse");
    endtask
    // Mid-run reset clears every output
    task automatic t_reset();
        @(negedge clk_sys_i);
        srst_i = 1'b1;
        repeat (2) @(negedge clk_sys_i);
        chk(lat === '0 && i_o === '0 && q_o === '0 && svalid === 1'b0 && mksync === 1'b0 && srsync === 1'b0, "reset");
        srst_i = 1'b0;
    endtask
    // Second rise restarts the count; only one pulse, timed from it
    task automatic t_sysref();
        int first;
        first = 0;
        for (int c = 0; c <= 700; c++) begin
            @(negedge clk_sys_i);
            sysref_i = (c < 100 || c >= 200);
            if (srsync === 1'b1 && first == 0) first = c;
        end
        @(negedge clk_sys_i);
        sysref_i = 1'b0;
        chk(first == 679, "sysref latency");
    endtask
    initial begin
        clk_sys_i = 1'b0;
        forever #5 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        srst_i = 1'b1;
        {sysref_i, send, mark, seed, phase} = '0;
        mode = LSMNC_M12_L6;
        factor = 8'h10;
        repeat (10) @(negedge clk_sys_i);
        srst_i = 1'b0;
        for (int k = 0; k < 6; k++) t_map(lsmnc_mode_e'(k), 4'(3 * k + 1));
        t_mark(8'h10, 4'h0, 290);
        t_mark(8'h20, 4'h0, 648);
        t_mark(8'h00, 4'h0, 6004);
        t_mark(8'h08, 4'h1, 94);
        t_mark(8'h04, 4'h3, -24);
        t_mark(8'h03, 4'h0, -89);
        t_reset();
        t_sysref();
        summarize();
    end
endmodule // lane_sample_mapper_nco_sync_bench
`default_nettype wire
